// *** bit_sync.sv ***
`default_nettype none
// =====================================================================
// Two-flop level synchroniser, one per bit
// =====================================================================
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage, read only by the second
  logic [WIDTH-1:0] meta;

  // Both stages clear on reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : bit_sync
`default_nettype wire

// *** dac_cmd_pkg.sv ***
`default_nettype none
// =====================================================================
// Shared constants for the serial command decoder
// =====================================================================
package dac_cmd_pkg;

  // Word layout
  localparam int CODE_W = 4;            // Control code width
  localparam int DATA_W = 10;           // DAC data width
  localparam int NUM_CH = 8;            // DAC channel count
  localparam int WORD_W = 16;           // DAC word and result word width
  localparam int CMD_W = 8;             // Command byte width
  localparam int GPIO_W = 12;           // Widest GPIO port set
  localparam int CNT_W = 5;             // Frame bit counter width

  // Field positions inside the 16-bit word
  localparam int CODE_LSB = 12;         // Control code sits in [15:12]
  localparam int DATA_LSB = 2;          // Data value sits in [11:2]
  localparam int MASK_LSB = 4;          // Channel mask sits in [11:4], channel 7 on top
  localparam int OPT_LSB = 1;           // Power option sits in [3:1]

  // Frame bit indices
  localparam logic [CNT_W-1:0] LAST_CMD_BIT = 5'h07;
  localparam logic [CNT_W-1:0] LAST_RES_BIT = 5'h0F;
  localparam logic [CNT_W-1:0] LAST_DAC_BIT = 5'h17;
  localparam logic [CNT_W-1:0] CNT_SAT = 5'h18;

  // Command bytes
  localparam logic [3:0] DAC_SELECT_NIBBLE = 4'h1;
  localparam logic [CMD_W-1:0] GPIO_READ_CMD = 8'h01;

  // Control codes
  localparam logic [3:0] NO_OPERATION_CODE = 4'h0;
  localparam logic [3:0] CODE_FILL = 4'h1;
  localparam logic [3:0] CODE_IN0 = 4'h2;
  localparam logic [3:0] CODE_GRP_LO = 4'hA;
  localparam logic [3:0] CODE_GRP_HI = 4'hB;
  localparam logic [3:0] CODE_ALL_THRU = 4'hC;
  localparam logic [3:0] CODE_ALL_IN = 4'hD;
  localparam logic [3:0] CODE_SW_LOAD = 4'hE;
  localparam logic [3:0] CODE_POWER = 4'hF;

  // Power options
  localparam logic [2:0] OPT_UP = 3'h1;
  localparam logic [2:0] OPT_HIZ = 3'h2;
  localparam logic [2:0] OPT_1K_GND = 3'h4;
  localparam logic [2:0] OPT_100K_GND = 3'h0;
  localparam logic [2:0] OPT_100K_REF = 3'h7;

  // Register fill values
  localparam logic [DATA_W-1:0] FILL_ZERO = 10'h000;
  localparam logic [DATA_W-1:0] FILL_ONES = 10'h3FF;

  // Output buffer states
  typedef enum logic [2:0]
  {
    BUF_ACTIVE = 3'h0,
    BUF_HIZ = 3'h1,
    BUF_1K_GND = 3'h3,
    BUF_100K_GND = 3'h2,
    BUF_100K_REF = 3'h6
  } buf_mode_t;

  localparam buf_mode_t BUF_RESET_MODE = BUF_100K_GND;

endpackage : dac_cmd_pkg
`default_nettype wire

// *** dac_gpio_serial_command_decoder.sv ***
// Functional notes
// - DAC word: code, ten data, two spare
// - Input bits captured on serial clock fall
// - Short frame discards the DAC word
// - Four-port GPIO read returns one byte
// - Twelve-port GPIO read returns two bytes
// - Code 1, top bit low: clear all
// - Code 1, top bit high: set all
// - Codes 2..9 load one input register
// - Code A writes channels 0..3 through
// - Code B writes channels 4..7 through
// - Code C writes all channels through
// - Code D loads all input registers only
// - Code E copies masked inputs to outputs
// - Code F option 001 powers masked buffers
// - Code F options 000, 010, 100, 111 power down masked
// - Result framed as two bytes, MSB first
// - Output bit changes on serial clock fall
// - Two's complement bipolar or temperature, binary otherwise
`default_nettype none
module dac_gpio_serial_command_decoder
  import dac_cmd_pkg::*;
#(
  parameter bit WIDE_GPIO = 1'b1
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  // GPIO pin states, port C in [11:8], B in [7:4], A in [3:0]
  input wire logic [GPIO_W-1:0] gpio_state,
  // Conversion result from the converter, same clock
  input wire logic result_load,
  input wire logic [DATA_W-1:0] result_code,
  input wire logic [1:0] result_sub,
  input wire logic result_bipolar,
  input wire logic result_temp,
  output logic result_free,
  // DAC state
  output logic [NUM_CH*DATA_W-1:0] dac_value,
  output logic [NUM_CH*DATA_W-1:0] input_value,
  output buf_mode_t buf_mode [NUM_CH]
);

  // =====================================================================
  // Link domain: frame counting and capture
  // =====================================================================

  logic frame_rst_n;                    // Frame reset, low outside frames
  logic [CNT_W-1:0] bit_cnt;            // Bits taken in this frame
  logic [WORD_W-1:0] in_sh;             // Input shift register
  logic [WORD_W-1:0] word_hold;         // Last complete DAC word
  logic word_tgl;                       // Flips per complete DAC word
  logic dac_frame;                      // Command byte selected the DAC
  logic res_frame;                      // Frame shifts a result out
  logic [WORD_W-1:0] out_sh;            // Output shift register
  logic taken_tgl;                      // Flips per result shifted out
  logic [GPIO_W-1:0] gpio_link;         // GPIO states on the link clock
  logic res_avail_link;                 // Load toggle seen on the link clock
  logic [WORD_W-1:0] res_word;          // Result word, stable while pending
  logic load_tgl;                       // Flips per result loaded, system side
  logic [CMD_W-1:0] cmd_now;            // Command byte with the current bit
  logic [WORD_W-1:0] gpio_word;         // GPIO read response

  // Frame signal ends every frame, so no edge after the last is needed
  assign frame_rst_n = rst_n & ~cs_n;
  assign cmd_now = {in_sh[CMD_W-2:0], din};

  // Response layout depends on the part variant
  always_comb
  begin
    if (WIDE_GPIO)
    begin
      gpio_word = {4'h0, gpio_link};
    end
    else
    begin
      gpio_word = {4'h0, gpio_link[9:8], gpio_link[1:0], 8'h00};
    end
  end

  // Pins are asynchronous to the link clock
  bit_sync #(.WIDTH(GPIO_W)) u_gpio_sync (
    .clk(sclk),
    .rst_n(rst_n),
    .async_in(gpio_state),
    .sync_out(gpio_link)
  );

  // Load toggle from the system domain; a level would go stale while the clock stops
  bit_sync #(.WIDTH(1)) u_avail_sync (
    .clk(sclk),
    .rst_n(rst_n),
    .async_in(load_tgl),
    .sync_out(res_avail_link)
  );

  // Bit counter and input shift, cleared by the frame signal
  always_ff @(negedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      bit_cnt <= '0;
      in_sh <= '0;
    end
    else
    begin
      in_sh <= {in_sh[WORD_W-2:0], din};
      if (bit_cnt != CNT_SAT)
      begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // Command byte decode, remembered for the rest of the frame
  always_ff @(negedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      dac_frame <= 1'b0;
    end
    else if (bit_cnt == LAST_CMD_BIT)
    begin
      dac_frame <= (cmd_now[CMD_W-1:4] == DAC_SELECT_NIBBLE);
    end
  end

  // Word capture happens only on the sixteenth word bit
  always_ff @(negedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_hold <= '0;
      word_tgl <= 1'b0;
    end
    else if (!cs_n && dac_frame && bit_cnt == LAST_DAC_BIT)
    begin
      word_hold <= {in_sh[WORD_W-2:0], din};
      word_tgl <= ~word_tgl;
    end
  end

  // =====================================================================
  // Link domain: serial output
  // =====================================================================

  // Output bit moves on the falling edge; the first bit is always zero
  always_ff @(negedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      dout <= 1'b0;
      out_sh <= '0;
      res_frame <= 1'b0;
    end
    else if (bit_cnt == '0 && (res_avail_link ^ taken_tgl))
    begin
      res_frame <= 1'b1;
      dout <= res_word[WORD_W-2];
      out_sh <= {res_word[WORD_W-3:0], 2'b00};
    end
    else if (bit_cnt == LAST_CMD_BIT && cmd_now == GPIO_READ_CMD)
    begin
      // Input bits during the response are ignored
      dout <= gpio_word[WORD_W-1];
      out_sh <= {gpio_word[WORD_W-2:0], 1'b0};
    end
    else
    begin
      dout <= out_sh[WORD_W-1];
      out_sh <= {out_sh[WORD_W-2:0], 1'b0};
    end
  end

  // A result counts as taken only after all sixteen bits went out
  always_ff @(negedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      taken_tgl <= 1'b0;
    end
    else if (!cs_n && res_frame && bit_cnt == LAST_RES_BIT)
    begin
      taken_tgl <= ~taken_tgl;
    end
  end

  // =====================================================================
  // System domain: crossings back from the link
  // =====================================================================

  logic word_tgl_s;                     // Synchronised word toggle
  logic word_tgl_d;                     // Previous synchronised value
  logic taken_tgl_s;                    // Synchronised taken toggle
  logic taken_tgl_d;                    // Previous synchronised value
  logic word_evt;                       // One word ready to apply
  logic [WORD_W-1:0] word_q;            // Word being applied
  logic [WORD_W-1:0] next_result;       // Framed result

  bit_sync #(.WIDTH(2)) u_tgl_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({word_tgl, taken_tgl}),
    .sync_out({word_tgl_s, taken_tgl_s})
  );

  // Word is stable long before its toggle lands here, so one sample is safe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_tgl_d <= 1'b0;
      taken_tgl_d <= 1'b0;
      word_evt <= 1'b0;
      word_q <= '0;
    end
    else
    begin
      word_tgl_d <= word_tgl_s;
      taken_tgl_d <= taken_tgl_s;
      word_evt <= word_tgl_s ^ word_tgl_d;
      if (word_tgl_s ^ word_tgl_d)
      begin
        word_q <= word_hold;
      end
    end
  end

  // =====================================================================
  // System domain: result holding
  // =====================================================================

  result_formatter u_fmt (
    .raw_code(result_code),
    .sub_bits(result_sub),
    .bipolar(result_bipolar),
    .temperature(result_temp),
    .framed(next_result)
  );

  // Loads are refused while a result waits, so the link never sees it move
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_free <= 1'b1;
      res_word <= '0;
      load_tgl <= 1'b0;
    end
    else if (result_free && result_load)
    begin
      result_free <= 1'b0;
      load_tgl <= ~load_tgl;
      res_word <= next_result;
    end
    else if (taken_tgl_s ^ taken_tgl_d)
    begin
      result_free <= 1'b1;
    end
  end

  // =====================================================================
  // System domain: DAC channels
  // =====================================================================

  logic [3:0] code;                     // Control code of the applied word
  logic [DATA_W-1:0] data;              // Data value of the applied word
  logic [NUM_CH-1:0] mask;              // Channel mask, channel 7 on top
  logic [2:0] opt;                      // Power option

  assign code = word_q[WORD_W-1:CODE_LSB];
  assign data = word_q[CODE_LSB-1:DATA_LSB];
  assign mask = word_q[CODE_LSB-1:MASK_LSB];
  assign opt = word_q[MASK_LSB-1:OPT_LSB];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      localparam logic [3:0] OWN_CODE = CODE_IN0 + 4'(ch);
      localparam bit LOW_HALF = (ch < NUM_CH / 2);
      logic wr_in;                      // Data goes to the input register
      logic wr_thru;                    // Data goes to the DAC register too
      logic fill;                       // Clear or set both registers

      always_comb
      begin
        fill = word_evt && code == CODE_FILL;
        wr_thru = word_evt && ((code == CODE_GRP_LO && LOW_HALF) ||
          (code == CODE_GRP_HI && !LOW_HALF) || code == CODE_ALL_THRU);
        wr_in = wr_thru || (word_evt && (code == OWN_CODE || code == CODE_ALL_IN));
      end

      // Input register; code 0 matches no branch and leaves it alone
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          input_value[ch*DATA_W +: DATA_W] <= FILL_ZERO;
        end
        else if (fill)
        begin
          input_value[ch*DATA_W +: DATA_W] <= data[DATA_W-1] ? FILL_ONES : FILL_ZERO;
        end
        else if (wr_in)
        begin
          input_value[ch*DATA_W +: DATA_W] <= data;
        end
      end

      // DAC register drives the output directly
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          dac_value[ch*DATA_W +: DATA_W] <= FILL_ZERO;
        end
        else if (fill)
        begin
          dac_value[ch*DATA_W +: DATA_W] <= data[DATA_W-1] ? FILL_ONES : FILL_ZERO;
        end
        else if (wr_thru)
        begin
          dac_value[ch*DATA_W +: DATA_W] <= data;
        end
        else if (word_evt && code == CODE_SW_LOAD && mask[ch])
        begin
          dac_value[ch*DATA_W +: DATA_W] <= input_value[ch*DATA_W +: DATA_W];
        end
      end

      // Buffer state; fill commands keep it, unknown options change nothing
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          buf_mode[ch] <= BUF_RESET_MODE;
        end
        else if (word_evt && code == CODE_POWER && mask[ch])
        begin
          case (opt)
            OPT_UP: buf_mode[ch] <= BUF_ACTIVE;
            OPT_HIZ: buf_mode[ch] <= BUF_HIZ;
            OPT_1K_GND: buf_mode[ch] <= BUF_1K_GND;
            OPT_100K_GND: buf_mode[ch] <= BUF_100K_GND;
            OPT_100K_REF: buf_mode[ch] <= BUF_100K_REF;
            default: buf_mode[ch] <= buf_mode[ch];
          endcase
        end
      end
    end
  endgenerate

  // =====================================================================
  // Checks
  // =====================================================================

  property p_nop_quiet;
    @(posedge clk) disable iff (!rst_n)
    word_evt && code == NO_OPERATION_CODE |=>
      $stable(input_value) && $stable(dac_value) && $stable(buf_mode[0]);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("no-op changed state");

  property p_fill_clear;
    @(posedge clk) disable iff (!rst_n)
    word_evt && code == CODE_FILL && !data[DATA_W-1] |=>
      input_value == '0 && dac_value == '0;
  endproperty
  a_fill_clear: assert property (p_fill_clear) else $error("clear left bits set");

  property p_fill_set;
    @(posedge clk) disable iff (!rst_n)
    word_evt && code == CODE_FILL && data[DATA_W-1] |=>
      input_value == '1 && dac_value == '1 && $stable(buf_mode[7]);
  endproperty
  a_fill_set: assert property (p_fill_set) else $error("set left bits clear");

  property p_single_load;
    @(posedge clk) disable iff (!rst_n)
    word_evt && code == 4'h5 |=>
      input_value[3*DATA_W +: DATA_W] == $past(data) && $stable(dac_value);
  endproperty
  a_single_load: assert property (p_single_load) else $error("single load wrong");

  property p_group_lo;
    @(posedge clk) disable iff (!rst_n)
    word_evt && code == CODE_GRP_LO |=>
      dac_value[4*DATA_W-1:0] == {4{$past(data)}} && $stable(dac_value[NUM_CH*DATA_W-1:4*DATA_W]);
  endproperty
  a_group_lo: assert property (p_group_lo) else $error("low group write wrong");

  property p_group_hi;
    @(posedge clk) disable iff (!rst_n)
    word_evt && code == CODE_GRP_HI |=>
      input_value[NUM_CH*DATA_W-1:4*DATA_W] == {4{$past(data)}} && $stable(dac_value[4*DATA_W-1:0]);
  endproperty
  a_group_hi: assert property (p_group_hi) else $error("high group write wrong");

  property p_all_thru;
    @(posedge clk) disable iff (!rst_n)
    word_evt && code == CODE_ALL_THRU |=> dac_value == {NUM_CH{$past(data)}};
  endproperty
  a_all_thru: assert property (p_all_thru) else $error("broadcast write wrong");

  property p_all_in;
    @(posedge clk) disable iff (!rst_n)
    word_evt && code == CODE_ALL_IN |=> input_value == {NUM_CH{$past(data)}} && $stable(dac_value);
  endproperty
  a_all_in: assert property (p_all_in) else $error("input-only write wrong");

  property p_sw_load;
    @(posedge clk) disable iff (!rst_n)
    word_evt && code == CODE_SW_LOAD && mask[6] && !mask[0] |=>
      dac_value[6*DATA_W +: DATA_W] == $past(input_value[6*DATA_W +: DATA_W]) &&
      $stable(dac_value[DATA_W-1:0]);
  endproperty
  a_sw_load: assert property (p_sw_load) else $error("masked copy wrong");

  property p_power_up;
    @(posedge clk) disable iff (!rst_n)
    word_evt && code == CODE_POWER && opt == OPT_UP && mask[7] |=> buf_mode[7] == BUF_ACTIVE;
  endproperty
  a_power_up: assert property (p_power_up) else $error("buffer not powered");

  property p_power_down;
    @(posedge clk) disable iff (!rst_n)
    word_evt && code == CODE_POWER && opt == OPT_HIZ |=>
      (buf_mode[4] == ($past(mask[4]) ? BUF_HIZ : $past(buf_mode[4])));
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down wrong");

  property p_dac_capture;
    @(posedge sclk) disable iff (!rst_n)
    !cs_n && dac_frame && bit_cnt == LAST_DAC_BIT |=> word_tgl != $past(word_tgl);
  endproperty
  a_dac_capture: assert property (p_dac_capture) else $error("word not captured");

  c_group: cover property (@(posedge clk) disable iff (!rst_n) word_evt && code == CODE_GRP_LO);
  c_sw_load: cover property (@(posedge clk) disable iff (!rst_n) word_evt && code == CODE_SW_LOAD);
  c_power: cover property (@(posedge clk) disable iff (!rst_n) word_evt && code == CODE_POWER);
  c_result: cover property (@(posedge clk) disable iff (!rst_n) !result_free ##1 result_free);

endmodule : dac_gpio_serial_command_decoder
`default_nettype wire

// *** dac_gpio_serial_command_decoder_tb.sv ***
`default_nettype none
// =====================================================================
// Self-checking bench for the command decoder
// =====================================================================
module dac_gpio_serial_command_decoder_tb
  import dac_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, sclk, cs_n, din, dout, result_load, result_free;
  logic result_bipolar, result_temp;
  logic [GPIO_W-1:0] gpio_state;
  logic [DATA_W-1:0] result_code;
  logic [1:0] result_sub;
  logic [NUM_CH*DATA_W-1:0] dac_value, input_value;
  buf_mode_t buf_mode [NUM_CH];
  // Expected register state
  logic [DATA_W-1:0] e_in [NUM_CH];
  logic [DATA_W-1:0] e_dac [NUM_CH];
  buf_mode_t e_buf [NUM_CH];
  logic [23:0] rx;
  logic dout_narrow;
  logic [23:0] narrow_sh;
  logic [15:0] pw [6] = '{16'hFF04, 16'hF0F8, 16'hF33E, 16'hF812, 16'hF180, 16'hFFF6};
  int error_cnt = 0;
  int num_checks = 0;

  // =====================================================================
  // Clock, design and host
  // =====================================================================
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  dac_gpio_serial_command_decoder i_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .gpio_state(gpio_state),
    .result_load(result_load), .result_code(result_code), .result_sub(result_sub),
    .result_bipolar(result_bipolar), .result_temp(result_temp),
    .result_free(result_free), .dac_value(dac_value), .input_value(input_value),
    .buf_mode(buf_mode));

  // Four-port variant on the same link, for its shorter response
  dac_gpio_serial_command_decoder #(.WIDE_GPIO(1'b0)) i_dut_narrow (
    .clk(clk), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout_narrow), .gpio_state(gpio_state),
    .result_load(result_load), .result_code(result_code), .result_sub(result_sub),
    .result_bipolar(result_bipolar), .result_temp(result_temp),
    .result_free(), .dac_value(), .input_value(), .buf_mode());

  spi_host i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  // Narrow variant's response, one bit per rising link clock edge
  always @(posedge sclk)
    narrow_sh <= {narrow_sh[22:0], dout_narrow};

  // =====================================================================
  // Checking
  // =====================================================================
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // Compare all registers with the expected image
  task automatic check_state();
    logic [79:0] ei;
    logic [79:0] ed;
    for (int c = 0; c < NUM_CH; c++)
    begin
      ei[c*DATA_W +: DATA_W] = e_in[c];
      ed[c*DATA_W +: DATA_W] = e_dac[c];
      chk(buf_mode[c], e_buf[c]);
    end
    chk(input_value, ei);
    chk(dac_value, ed);
  endtask : check_state

  // Idle outputs right after reset
  task automatic reset_values();
    repeat (3) @(posedge clk);
    chk(result_free, 1'b1);
    chk(dout, 1'b0);
    check_state();
  endtask : reset_values

  // Read the pin states back through both variants
  task automatic gpio_read();
    i_host.xfer(24'h01FFFF, 24, rx);
    @(posedge clk);
    chk(rx, {12'h000, gpio_state});
    chk(narrow_sh, {11'h000, gpio_state[9:8], gpio_state[1:0], 9'h000});
  endtask : gpio_read

  // Send one DAC word; a short frame must change nothing
  task automatic dac(input logic [15:0] w, input int n);
    logic [3:0] code;
    code = w[15:12];
    i_host.xfer({8'h1A, w}, n, rx);
    // Word applies a few cycles after the last fall, plus sync
    repeat (20) @(posedge clk);
    for (int c = 0; c < NUM_CH && n == 24; c++)
    begin
      if (code == 4'h1)
      begin
        e_in[c] = w[11] ? 10'h3FF : 10'h000;
        e_dac[c] = e_in[c];
      end
      if (code == c + 2 || code == 4'hD)
        e_in[c] = w[11:2];
      if (code == 4'hC || code == 4'hA && c < 4 || code == 4'hB && c > 3)
      begin
        e_in[c] = w[11:2];
        e_dac[c] = w[11:2];
      end
      if (code == 4'hE && w[4+c])
        e_dac[c] = e_in[c];
      // Unknown options leave the buffer alone
      if (code == 4'hF && w[4+c])
        case (w[3:1])
          3'h1: e_buf[c] = BUF_ACTIVE;
          3'h2: e_buf[c] = BUF_HIZ;
          3'h4: e_buf[c] = BUF_1K_GND;
          3'h0: e_buf[c] = BUF_100K_GND;
          3'h7: e_buf[c] = BUF_100K_REF;
          default: ;
        endcase
    end
    check_state();
  endtask : dac

  // Post a result, read it back, wait until it is taken
  task automatic result(input logic [9:0] rc, input logic bip, input logic tmp);
    @(posedge clk);
    result_code <= rc;
    result_sub <= 2'h2;
    result_bipolar <= bip;
    result_temp <= tmp;
    result_load <= 1'b1;
    @(posedge clk);
    result_load <= 1'b0;
    @(negedge clk);
    chk(result_free, 1'b0);
    // Short frame only moves the pending flag across
    i_host.xfer(24'h000000, 4, rx);
    i_host.xfer(24'h000000, 16, rx);
    chk(rx[23:8], {4'h0, rc ^ {bip | tmp, 9'h000}, 2'h2});
    for (int t = 0; t < 100 && result_free !== 1'b1; t++)
      @(posedge clk);
    if (result_free !== 1'b1)
    begin
      error_cnt++;
      results();
    end
  endtask : result

  // =====================================================================
  // Main sequence
  // =====================================================================
  initial
  begin
    rst_n = 1'b0;
    result_load = 1'b0;
    result_code = 10'h000;
    result_sub = 2'h0;
    result_bipolar = 1'b0;
    result_temp = 1'b0;
    gpio_state = 12'hC5A;
    for (int c = 0; c < NUM_CH; c++)
    begin
      e_in[c] = 10'h000;
      e_dac[c] = 10'h000;
      e_buf[c] = BUF_100K_GND;
    end
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    reset_values();
    dac(16'h1800, 24);
    for (int k = 0; k < 8; k++)
      dac({4'(k + 2), 10'(k * 73 + 5), 2'h3}, 24);
    dac(16'hE5A0, 24);
    dac(16'hA5E4, 24);
    dac(16'hB19C, 24);
    dac(16'hD2A8, 24);
    dac(16'hC3FC, 24);
    dac(16'h0FFF, 24);
    dac(16'h2ABC, 20);
    dac(16'h1000, 24);
    foreach (pw[k])
      dac(pw[k], 24);
    gpio_read();
    result(10'h2B3, 1'b0, 1'b0);
    result(10'h0C5, 1'b1, 1'b0);
    result(10'h31E, 1'b0, 1'b1);
    results();
  end
endmodule : dac_gpio_serial_command_decoder_tb
`default_nettype wire

// *** result_formatter.sv ***
`default_nettype none
// =====================================================================
// Conversion result framing and coding
// =====================================================================
module result_formatter
  import dac_cmd_pkg::*;
(
  // Raw converter result, offset binary
  input wire logic [DATA_W-1:0] raw_code,
  input wire logic [1:0] sub_bits,
  // Coding select
  input wire logic bipolar,
  input wire logic temperature,
  // Framed word, first bit out in [15]
  output logic [WORD_W-1:0] framed
);

  // Two's complement is offset binary with the top bit turned over
  logic twos;

  always_comb
  begin
    twos = bipolar | temperature;
    framed = {4'h0, raw_code[DATA_W-1] ^ twos, raw_code[DATA_W-2:0], sub_bits};
  end

endmodule : result_formatter
`default_nettype wire

// *** spi_host.sv ***
`default_nettype none
// =====================================================================
// Serial host model; clock idles high and stands still between frames
// =====================================================================
module spi_host
(
  // Link
  output var logic sclk,
  output var logic cs_n,
  output var logic din,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: deselected, clock parked
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // One frame of n bits, first bit from tx[23]; rx[23-i] holds bit i
  task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
    rx = '0;
    #3;
    cs_n = 1'b0;
    #40;
    for (int i = 0; i < n; i++)
    begin
      // Bit i shows after the previous fall
      rx[23-i] = dout;
      din = tx[23-i];
      #40 sclk = 1'b0;
      #40 sclk = 1'b1;
    end
    cs_n = 1'b1;
    // Released line must not keep its last level
    din = ~din;
  endtask : xfer
endmodule : spi_host
`default_nettype wire
